//--- hdl/uevf_params.svh
// Offsets, field positions, reset values and timing for the UART event
// flag and shortcut block. Included by the package users only.
`ifndef UEVF_PARAMS_SVH
`define UEVF_PARAMS_SVH

// Register byte offsets
`define UEVF_OFS_CTS_ACT      12'h100
`define UEVF_OFS_CTS_REL      12'h104
`define UEVF_OFS_RX_READY     12'h108
`define UEVF_OFS_TX_SENT      12'h11C
`define UEVF_OFS_ERROR        12'h124
`define UEVF_OFS_RX_TIMEOUT   12'h144
`define UEVF_OFS_SHORTCUTS    12'h200
`define UEVF_OFS_INT_SET      12'h304
`define UEVF_OFS_INT_CLR      12'h308
`define UEVF_OFS_INT_STATUS   12'h30C
`define UEVF_OFS_INT_PEND     12'h310

// Event bit positions in the enable and status layout
`define UEVF_EV_CTS_ACT       0
`define UEVF_EV_CTS_REL       1
`define UEVF_EV_RX_READY      2
`define UEVF_EV_TX_SENT       3
`define UEVF_EV_ERROR         4
`define UEVF_EV_RX_TIMEOUT    5
`define UEVF_NUM_EVENTS       6

// Shortcut bit positions
`define UEVF_SC_START_BIT     0
`define UEVF_SC_STOP_BIT      1

// Reset values
`define UEVF_RST_EVENTS       6'h00
`define UEVF_RST_SHORTCUTS    2'h0
`define UEVF_RST_ENABLES      6'h00
`define UEVF_RST_CTS_LEVEL    1'h1

// Cycles the slave spends in its wait phase; waitrequest stays high one cycle more
`define UEVF_WAIT_CYCLES      1

`endif

//--- hdl/uevf_pkg.sv
// Types of the UART event flag and shortcut block.
// Assumes the params header is compiled alongside.
package uevf_pkg;

	// Bus slave phases
	typedef enum logic [1:0] {
		UEVF_IDLE,
		UEVF_WAIT,
		UEVF_DONE
	} uevf_bus_state_t;

	// One Avalon request, as presented on the bus
	typedef struct packed {
		logic [11:0] addr;
		logic        rd;
		logic        wr;
		logic [31:0] wdata;
	} uevf_req_t;

	// Hardware event pulses from the UART core
	typedef struct packed {
		logic rx_timeout;
		logic error;
		logic tx_sent;
		logic rx_ready;
	} uevf_core_ev_t;

	// Tasks issued to the receiver
	typedef struct packed {
		logic stop;
		logic start;
	} uevf_tasks_t;

endpackage

//--- hdl/uevf_edge.sv
// Edge detector for the clear-to-send level.
// Assumes the level is already synchronous to clk_sys.
`timescale 1ns/1ps
`include "uevf_params.svh"

module uevf_edge
	import uevf_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Level in, edges out
	input  wire logic level_n,
	output logic      fell,
	output logic      rose
);

	logic last_q;
	logic last_d;

	// Next sampled level
	always_comb begin
		last_d = level_n;
	end

	// Line idles released, so no edge at reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			last_q <= `UEVF_RST_CTS_LEVEL;
		end else begin
			last_q <= last_d;
		end
	end

	// Edge terms
	assign fell = last_q & ~level_n;
	assign rose = ~last_q & level_n;

endmodule // uevf_edge

//--- hdl/uevf_top.sv
// Event flags, interrupt enables and event-to-task shortcuts of a UART.
// Assumes core event inputs are one-cycle pulses synchronous to clk_sys
// and an Avalon-MM master that holds its request during waitrequest.
`timescale 1ns/1ps
`include "uevf_params.svh"

// Notes on behaviour
// - CTS falling sets active flag at 0x100
// - CTS rising sets released flag at 0x104
// - Received character sets ready flag 0x108
// - Shortcut bit 0: CTS active starts receiver
// - Shortcut bit 1: CTS release stops receiver
// - Shortcut register at 0x200, resets zero
// - Enable set/clear registers read enable state
module uevf_top
	import uevf_pkg::*;
#(
	parameter int WAIT_CYCLES = `UEVF_WAIT_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Avalon-MM slave
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Clear-to-send pin, active low
	input  wire logic        cts_n,
	// Event pulses from the UART core
	input  wire logic        rx_char_ready,
	input  wire logic        tx_char_sent,
	input  wire logic        rx_error,
	input  wire logic        rx_timed_out,
	// Receiver tasks and interrupt
	output logic             receiver_start_task,
	output logic             receiver_stop_task,
	output logic             irq
);

	localparam int NEV = `UEVF_NUM_EVENTS;

	// Refuse wait counts that the 4-bit counter cannot serve
	if (WAIT_CYCLES < 1 || WAIT_CYCLES > 15) begin : g_bad_wait
		$error("WAIT_CYCLES must be 1 to 15");
	end

	// Map a byte offset to an event index, or NEV when not a flag
	function automatic int ev_index(input logic [11:0] a);
		if (a == `UEVF_OFS_CTS_ACT) return `UEVF_EV_CTS_ACT;
		else if (a == `UEVF_OFS_CTS_REL) return `UEVF_EV_CTS_REL;
		else if (a == `UEVF_OFS_RX_READY) return `UEVF_EV_RX_READY;
		else if (a == `UEVF_OFS_TX_SENT) return `UEVF_EV_TX_SENT;
		else if (a == `UEVF_OFS_ERROR) return `UEVF_EV_ERROR;
		else if (a == `UEVF_OFS_RX_TIMEOUT) return `UEVF_EV_RX_TIMEOUT;
		else return NEV;
	endfunction

	// State
	uevf_bus_state_t   st_q, st_d;
	logic [3:0]        cnt_q, cnt_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              wait_q, wait_d;
	logic [NEV-1:0]    flags_q, flags_d;
	logic [NEV-1:0]    inten_q, inten_d;
	logic [1:0]        short_q, short_d;
	uevf_tasks_t       task_q, task_d;
	logic              irq_q, irq_d;
	logic              cts_fell, cts_rose;
	logic [NEV-1:0]    ev_set;
	uevf_req_t         req;
	logic              commit;

	// Clear-to-send edges
	uevf_edge u_edge (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.level_n (cts_n),
		.fell    (cts_fell),
		.rose    (cts_rose)
	);

	// Gather incoming events
	always_comb begin
		ev_set = '0;
		ev_set[`UEVF_EV_CTS_ACT] = cts_fell;
		ev_set[`UEVF_EV_CTS_REL] = cts_rose;
		ev_set[`UEVF_EV_RX_READY] = rx_char_ready;
		ev_set[`UEVF_EV_TX_SENT] = tx_char_sent;
		ev_set[`UEVF_EV_ERROR] = rx_error;
		ev_set[`UEVF_EV_RX_TIMEOUT] = rx_timed_out;
	end

	// Bus request view
	always_comb begin
		req.addr = avs_address;
		req.rd = avs_read;
		req.wr = avs_write;
		req.wdata = avs_writedata;
	end

	// Bus slave sequencing: waits WAIT_CYCLES, then answers one cycle
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		commit = 1'b0;
		case (st_q)
			UEVF_IDLE: begin
				if (req.rd || req.wr) begin
					st_d = UEVF_WAIT;
					cnt_d = 4'h1;
				end
			end
			UEVF_WAIT: begin
				if (cnt_q >= WAIT_CYCLES[3:0]) begin
					st_d = UEVF_DONE;
					commit = 1'b1;
				end else begin
					cnt_d = cnt_q + 4'h1;
				end
			end
			UEVF_DONE: begin
				st_d = UEVF_IDLE;
			end
			default: begin
				st_d = UEVF_IDLE;
			end
		endcase
		// Waitrequest drops only in the answer cycle
		wait_d = ~commit;
	end

	// Register file next values and read mux
	always_comb begin
		int idx;
		idx = ev_index(req.addr);
		flags_d = flags_q;
		inten_d = inten_q;
		short_d = short_q;
		rdata_d = rdata_q;
		if (commit && req.wr) begin
			if (idx < NEV) begin
				// Software writes 0 to clear, 1 to set
				flags_d[idx] = req.wdata[0];
			end else if (req.addr == `UEVF_OFS_SHORTCUTS) begin
				short_d = req.wdata[1:0];
			end else if (req.addr == `UEVF_OFS_INT_SET) begin
				inten_d = inten_q | req.wdata[NEV-1:0];
			end else if (req.addr == `UEVF_OFS_INT_CLR) begin
				inten_d = inten_q & ~req.wdata[NEV-1:0];
			end
		end
		flags_d = flags_d | ev_set;
		if (commit && req.rd) begin
			rdata_d = 32'h0000_0000;
			if (idx < NEV) begin
				rdata_d[0] = flags_q[idx];
			end else if (req.addr == `UEVF_OFS_SHORTCUTS) begin
				rdata_d[1:0] = short_q;
			end else if (req.addr == `UEVF_OFS_INT_SET
				|| req.addr == `UEVF_OFS_INT_CLR) begin
				rdata_d[NEV-1:0] = inten_q;
			end else if (req.addr == `UEVF_OFS_INT_STATUS) begin
				rdata_d[NEV-1:0] = flags_q;
			end else if (req.addr == `UEVF_OFS_INT_PEND) begin
				rdata_d[NEV-1:0] = flags_q & inten_q;
			end
		end
	end

	// Shortcut tasks and interrupt
	always_comb begin
		task_d.start = short_q[`UEVF_SC_START_BIT] & cts_fell;
		task_d.stop = short_q[`UEVF_SC_STOP_BIT] & cts_rose;
		irq_d = |(flags_d & inten_d);
	end

	// Registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q <= UEVF_IDLE;
			cnt_q <= 4'h0;
			rdata_q <= 32'h0000_0000;
			wait_q <= 1'b1;
			flags_q <= `UEVF_RST_EVENTS;
			inten_q <= `UEVF_RST_ENABLES;
			short_q <= `UEVF_RST_SHORTCUTS;
			task_q <= '0;
			irq_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
			flags_q <= flags_d;
			inten_q <= inten_d;
			short_q <= short_d;
			task_q <= task_d;
			irq_q <= irq_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign receiver_start_task = task_q.start;
	assign receiver_stop_task = task_q.stop;
	assign irq = irq_q;

	// Assertions
	property p_cts_act;
		@(posedge clk_sys) disable iff (!rstn)
		cts_fell |=> flags_q[`UEVF_EV_CTS_ACT];
	endproperty
	a_cts_act: assert property (p_cts_act)
		else $error("active flag missed");

	property p_cts_rel;
		@(posedge clk_sys) disable iff (!rstn)
		cts_rose |=> flags_q[`UEVF_EV_CTS_REL];
	endproperty
	a_cts_rel: assert property (p_cts_rel)
		else $error("release flag missed");

	property p_rx_ready;
		@(posedge clk_sys) disable iff (!rstn)
		rx_char_ready |=> flags_q[`UEVF_EV_RX_READY];
	endproperty
	a_rx_ready: assert property (p_rx_ready)
		else $error("ready flag missed");

	sequence s_fall_short;
		(cts_n == 1'b1) ##1 (cts_n == 1'b0 && short_q[0]);
	endsequence
	property p_start;
		@(posedge clk_sys) disable iff (!rstn)
		s_fall_short |=> receiver_start_task ##1 !receiver_start_task;
	endproperty
	a_start: assert property (p_start)
		else $error("start task missed");

	property p_stop;
		@(posedge clk_sys) disable iff (!rstn)
		receiver_stop_task |-> $past(cts_rose) && $past(short_q[1]);
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop task unexpected");

	property p_stop_fire;
		@(posedge clk_sys) disable iff (!rstn)
		cts_rose && short_q[`UEVF_SC_STOP_BIT] |=> receiver_stop_task;
	endproperty
	a_stop_fire: assert property (p_stop_fire)
		else $error("stop task missed");

	property p_short_zero;
		@(posedge clk_sys) disable iff (!rstn)
		short_q == 2'h0 |=> !receiver_start_task && !receiver_stop_task;
	endproperty
	a_short_zero: assert property (p_short_zero)
		else $error("shortcut off fired");

	property p_sc_write;
		@(posedge clk_sys) disable iff (!rstn)
		commit && avs_write && avs_address == `UEVF_OFS_SHORTCUTS
			|=> short_q == $past(avs_writedata[1:0]);
	endproperty
	a_sc_write: assert property (p_sc_write)
		else $error("shortcut write lost");

	property p_sticky;
		@(posedge clk_sys) disable iff (!rstn)
		flags_q[`UEVF_EV_ERROR] && !(commit && avs_write
			&& avs_address == `UEVF_OFS_ERROR) |=> flags_q[`UEVF_EV_ERROR];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("error flag lost");

	property p_irq;
		@(posedge clk_sys) disable iff (!rstn)
		irq == (|(flags_q & inten_q));
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq level wrong");

	property p_inten_set;
		@(posedge clk_sys) disable iff (!rstn)
		commit && avs_write && avs_address == `UEVF_OFS_INT_SET
			|=> (inten_q & $past(avs_writedata[NEV-1:0]))
			== $past(avs_writedata[NEV-1:0]);
	endproperty
	a_inten_set: assert property (p_inten_set)
		else $error("enable set lost");

	property p_inten_clr;
		@(posedge clk_sys) disable iff (!rstn)
		commit && avs_write && avs_address == `UEVF_OFS_INT_CLR
			|=> (inten_q & $past(avs_writedata[NEV-1:0])) == '0;
	endproperty
	a_inten_clr: assert property (p_inten_clr)
		else $error("enable clear lost");

endmodule // uevf_top

//--- verif/uevf_cts_peer.sv
// Far-side serial device: drives the clear-to-send line.
// Assumes the bench clock; the line rests released (high).
`timescale 1ns/1ps
module uevf_cts_peer (
	// Clock
	input  wire logic clk_sys,
	// Clear-to-send line, active low
	output logic      cts_n
);
	// Released line rests high, like a pulled-up pin
	initial cts_n = 1'b1;

	// Change the line just after a rising edge
	task automatic drive(input logic lvl);
		@(posedge clk_sys);
		cts_n <= lvl;
	endtask
endmodule // uevf_cts_peer

//--- verif/uevf_top_tb.sv
// Bench for the event flags: bus tasks, CTS peer, core pulses.
// Assumes the design package and params header are compiled first.
`timescale 1ns/1ps
`include "uevf_params.svh"
module uevf_top_tb
	import uevf_pkg::*;
;
	logic        clk_sys, rstn, avs_read, avs_write, cts_n, irq;
	logic        avs_waitrequest, start_t, stop_t;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdq;
	logic [3:0]  ev;
	int          fail_count, num_checks, n_start, n_stop;
	logic [11:0] ev_ofs [4] = '{`UEVF_OFS_RX_READY, `UEVF_OFS_TX_SENT,
		`UEVF_OFS_ERROR, `UEVF_OFS_RX_TIMEOUT};

	uevf_top u_dut (.clk_sys(clk_sys), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cts_n(cts_n), .rx_char_ready(ev[0]), .tx_char_sent(ev[1]),
		.rx_error(ev[2]), .rx_timed_out(ev[3]),
		.receiver_start_task(start_t), .receiver_stop_task(stop_t),
		.irq(irq));
	uevf_cts_peer u_peer (.clk_sys(clk_sys), .cts_n(cts_n));

	// 125 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Count receiver task pulses
	always @(posedge clk_sys) begin
		if (start_t === 1'b1) n_start++;
		if (stop_t === 1'b1) n_stop++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		avs_read <= ~w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		// Sample the answer on rising edges; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rdq = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdq, e);
	endtask

	// Let the interrupt level settle, then compare it
	task automatic chk_irq(input logic e);
		repeat (2) @(negedge clk_sys);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	task automatic pulse(input logic [3:0] p);
		@(posedge clk_sys);
		ev <= p;
		@(posedge clk_sys);
		ev <= 4'h0;
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#40000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		give_verdict;
	end

	// Main sequence
	initial begin
		rstn = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata, ev} = '0;
		{fail_count, num_checks, n_start, n_stop} = '0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(`UEVF_OFS_CTS_ACT, 32'h0);
		rd(`UEVF_OFS_CTS_REL, 32'h0);
		for (int i = 0; i < 4; i++) rd(ev_ofs[i], 32'h0);
		rd(`UEVF_OFS_SHORTCUTS, 32'h0);
		rd(`UEVF_OFS_INT_SET, 32'h0);
		rd(12'h400, 32'h0);
		$display("test reset values done");
		// Shortcuts on: CTS edges fire receiver tasks
		wr(`UEVF_OFS_SHORTCUTS, 32'h3);
		rd(`UEVF_OFS_SHORTCUTS, 32'h3);
		u_peer.drive(1'b0);
		repeat (3) @(posedge clk_sys);
		chk(n_start, 1);
		chk(n_stop, 0);
		rd(`UEVF_OFS_CTS_ACT, 32'h1);
		u_peer.drive(1'b1);
		repeat (3) @(posedge clk_sys);
		chk(n_stop, 1);
		rd(`UEVF_OFS_CTS_REL, 32'h1);
		// Shortcuts off: flags still set, no tasks
		wr(`UEVF_OFS_CTS_ACT, 32'h0);
		wr(`UEVF_OFS_CTS_REL, 32'h0);
		rd(`UEVF_OFS_CTS_ACT, 32'h0);
		wr(`UEVF_OFS_SHORTCUTS, 32'h0);
		u_peer.drive(1'b0);
		u_peer.drive(1'b1);
		repeat (3) @(posedge clk_sys);
		chk(n_start, 1);
		chk(n_stop, 1);
		rd(`UEVF_OFS_CTS_ACT, 32'h1);
		rd(`UEVF_OFS_CTS_REL, 32'h1);
		$display("test shortcuts done");
		// Each core pulse sets only its own flag
		for (int i = 0; i < 4; i++) begin
			pulse(4'(1 << i));
			rd(ev_ofs[i], 32'h1);
			rd(`UEVF_OFS_INT_STATUS, 32'h3 | (32'h4 << i));
			wr(ev_ofs[i], 32'h0);
			rd(ev_ofs[i], 32'h0);
		end
		$display("test core flags done");
		// Interrupt enable, mask and clear
		pulse(4'h1);
		chk_irq(1'b0);
		wr(`UEVF_OFS_INT_SET, 32'h4);
		chk_irq(1'b1);
		rd(`UEVF_OFS_INT_CLR, 32'h4);
		rd(`UEVF_OFS_INT_PEND, 32'h4);
		wr(`UEVF_OFS_INT_CLR, 32'h4);
		chk_irq(1'b0);
		rd(`UEVF_OFS_INT_SET, 32'h0);
		wr(`UEVF_OFS_INT_SET, 32'h4);
		wr(`UEVF_OFS_RX_READY, 32'h0);
		chk_irq(1'b0);
		$display("test interrupt done");
		give_verdict;
	end
endmodule // uevf_top_tb
